/* File: pkg/pci_cs_pkg.sv */
// Purpose: constants and carrier types for the command/status register bank
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets 0x04/0x06 keep a word each; see hand-over for the layout
package pci_cs_pkg;
   // printed offsets are not all multiples of four: they are indices
   localparam logic [7:0] CMD_IDX = 8'h04;
   localparam logic [7:0] STS_IDX = 8'h06;
   localparam logic [7:0] CTL_IDX = 8'h08;
   localparam logic [11:0] CMD_ADDR = {2'h0, CMD_IDX, 2'h0};
   localparam logic [11:0] STS_ADDR = {2'h0, STS_IDX, 2'h0};
   localparam logic [11:0] CTL_ADDR = {2'h0, CTL_IDX, 2'h0};
   // command bit positions
   localparam int CMD_IO = 0;
   localparam int CMD_MEM = 1;
   localparam int CMD_MASTER = 2;
   localparam int CMD_SPECIAL = 3;
   localparam int CMD_MWI = 4;
   localparam int CMD_PERR_RESP = 6;
   localparam int CMD_SERR_EN = 8;
   // status bit positions
   localparam int STS_DPD = 8;
   localparam int STS_FB2B = 7;
   localparam int STS_SIG_TA = 11;
   localparam int STS_RCV_TA = 12;
   localparam int STS_RCV_MA = 13;
   localparam int STS_SIG_SERR = 14;
   localparam int STS_DET_PERR = 15;
   // reset values, write masks and fixed status bits
   localparam logic [15:0] CMD_RESET = 16'h0006;
   localparam logic [15:0] CMD_WMASK = 16'h0146;
   localparam logic [15:0] STS_FIXED = 16'h0080;
   localparam logic [15:0] STS_W1C = 16'hF900;
   localparam logic CTL_TEA_RESET = 1'h0;

   // pci-side event strobes, one cycle each
   typedef struct packed {
      logic addr_perr;
      logic data_perr;
      logic master_active;
      logic master_abort;
      logic target_abort_rcvd;
      logic target_abort_sent;
      logic special_cycle;
   } pci_event_t;

   // decode of a target-side command
   typedef struct packed {
      logic valid;
      logic is_mem;
      logic is_io;
      logic is_special;
   } tgt_cmd_t;

   // processor-bus request headed to pci
   typedef struct packed {
      logic valid;
      logic write;
   } cpu_req_t;
endpackage

/* File: verilog/pci_command_status_regs.sv */
// Purpose: pci command and status registers with their effects
// Assumes: event strobes come from pci logic on pclk
// Notes: apb slave answers with pready in the access cycle itself
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns
module pci_command_status_regs (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire pci_cs_pkg::pci_event_t pci_event,
   input wire pci_cs_pkg::tgt_cmd_t tgt_cmd,
   input wire pci_cs_pkg::cpu_req_t cpu_req,
   output logic master_enable_r,
   output logic mem_claim_r,
   output logic serr_drive_r,
   output logic perr_action_r,
   output logic fast_devsel_r,
   output logic use_plain_write_r,
   output logic cpu_write_drop_r,
   output logic transfer_error_ack,
   output logic cpu_req_forward_r
);
   logic [15:0] cmd_r;
   logic [15:0] sts_r;
   logic [15:0] sts_nxt;
   logic transfer_error_report_enable;
   logic wr_en;
   logic rd_en;
   logic [31:0] rd_nxt;
   logic [15:0] sts_set;
   logic [15:0] sts_clr;
   logic claim_nxt;

   // command word map, bits 15:0 of the word at the command index
   //   bit 8   system error driver enable, writable, resets 0
   //   bit 7   reserved, reads 0
   //   bit 6   parity response enable, writable, resets 0
   //   bit 5   reserved, reads 0
   //   bit 4   invalidate-write enable, hardwired 0
   //   bit 3   special-cycle enable, hardwired 0
   //   bit 2   master enable, writable, resets 1
   //   bit 1   memory space enable, writable, resets 1
   //   bit 0   io space enable, hardwired 0
   // status word map, bits 15:0 of the word at the status index
   //   bit 15  detected parity error, write one to clear
   //   bit 14  signaled system error, write one to clear
   //   bit 13  received master abort, write one to clear
   //   bit 12  received target abort, write one to clear
   //   bit 11  signaled target abort, write one to clear
   //   bits 10:9 select timing, hardwired 00 (fast)
   //   bit 8   data parity detected, write one to clear
   //   bit 7   fast back-to-back capable, hardwired 1
   //   bit 6   reserved, reads 0
   //   bit 5   66 MHz capable, hardwired 0
   //   bits 4:0 reserved, read 0
   // processor control word, bit 0 error-ack reporting, resets 0
   // limitation: only the flags are stored; constants are merged on read
   // so a write can never disturb them

   // address decode used by read and write paths alike
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] base);
      hit = (a == base);
   endfunction

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   // command: only master, memory, parity and serr bits are writable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_r <= pci_cs_pkg::CMD_RESET;
      end else if (wr_en && hit(paddr, pci_cs_pkg::CMD_ADDR)) begin
         // fixed io, special, invalidate and reserved bits stay zero
         cmd_r <= pwdata[15:0] & pci_cs_pkg::CMD_WMASK;
      end
   end

   // processor interface control, holds the error-ack enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         transfer_error_report_enable <= pci_cs_pkg::CTL_TEA_RESET;
      end else if (wr_en && hit(paddr, pci_cs_pkg::CTL_ADDR) && pstrb[0]) begin
         transfer_error_report_enable <= pwdata[0];
      end
   end

   // status event sources
   always_comb begin
      sts_set = 16'h0000;
      sts_set[pci_cs_pkg::STS_DET_PERR] =
         pci_event.addr_perr || pci_event.data_perr;
      // system error asserted only through the enabled driver
      sts_set[pci_cs_pkg::STS_SIG_SERR] = pci_event.addr_perr &&
         cmd_r[pci_cs_pkg::CMD_SERR_EN] &&
         cmd_r[pci_cs_pkg::CMD_PERR_RESP];
      sts_set[pci_cs_pkg::STS_RCV_MA] =
         pci_event.master_abort && !pci_event.special_cycle;
      sts_set[pci_cs_pkg::STS_RCV_TA] =
         pci_event.target_abort_rcvd && !pci_event.special_cycle;
      sts_set[pci_cs_pkg::STS_SIG_TA] = pci_event.target_abort_sent;
      sts_set[pci_cs_pkg::STS_DPD] = pci_event.data_perr &&
         pci_event.master_active &&
         cmd_r[pci_cs_pkg::CMD_PERR_RESP];
   end

   // write-one-to-clear; low bytes of the word only
   always_comb begin
      sts_clr = 16'h0000;
      if (wr_en && hit(paddr, pci_cs_pkg::STS_ADDR)) begin
         sts_clr[7:0] = pstrb[0] ? pwdata[7:0] : 8'h00;
         sts_clr[15:8] = pstrb[1] ? pwdata[15:8] : 8'h00;
      end
      sts_clr = sts_clr & pci_cs_pkg::STS_W1C;
      // set applied after clear so a coinciding event survives
      sts_nxt = ((sts_r & ~sts_clr) | sts_set) & pci_cs_pkg::STS_W1C;
   end

   // status flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sts_r <= 16'h0000;
      end else begin
         sts_r <= sts_nxt;
      end
   end

   // read mux; constant bits merged here, not stored
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit(paddr, pci_cs_pkg::CMD_ADDR)) begin
         rd_nxt[15:0] = cmd_r;
      end else if (hit(paddr, pci_cs_pkg::STS_ADDR)) begin
         // timing 00, fast b2b one, 66 MHz zero, reserved zero
         rd_nxt[15:0] = sts_r | pci_cs_pkg::STS_FIXED;
      end else if (hit(paddr, pci_cs_pkg::CTL_ADDR)) begin
         rd_nxt[0] = transfer_error_report_enable;
      end
   end

   // apb answer registered; zero-wait combinational ready would break
   // the flop-output style, so ready is registered in the setup cycle and is high in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'h0;
         pslverr <= 1'h0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !(hit(paddr, pci_cs_pkg::CMD_ADDR) ||
            hit(paddr, pci_cs_pkg::STS_ADDR) ||
            hit(paddr, pci_cs_pkg::CTL_ADDR));
         prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
      end
   end

   // target claim: memory only when enabled, never io or special
   assign claim_nxt = tgt_cmd.valid && tgt_cmd.is_mem &&
      !tgt_cmd.is_io && !tgt_cmd.is_special &&
      cmd_r[pci_cs_pkg::CMD_MEM];

   // control outputs, registered one cycle after the source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_enable_r <= 1'h1;
         mem_claim_r <= 1'h0;
         serr_drive_r <= 1'h0;
         perr_action_r <= 1'h0;
         fast_devsel_r <= 1'h1;
         use_plain_write_r <= 1'h1;
      end else begin
         master_enable_r <= cmd_r[pci_cs_pkg::CMD_MASTER];
         mem_claim_r <= claim_nxt;
         serr_drive_r <= cmd_r[pci_cs_pkg::CMD_SERR_EN];
         perr_action_r <= cmd_r[pci_cs_pkg::CMD_PERR_RESP];
         fast_devsel_r <= 1'h1;
         use_plain_write_r <= 1'h1;
      end
   end

   // processor-bus requests: forward, drop or error-ack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_req_forward_r <= 1'h0;
         cpu_write_drop_r <= 1'h0;
         transfer_error_ack <= 1'h0;
      end else begin
         cpu_req_forward_r <= cpu_req.valid &&
            cmd_r[pci_cs_pkg::CMD_MASTER];
         cpu_write_drop_r <= cpu_req.valid && cpu_req.write &&
            !cmd_r[pci_cs_pkg::CMD_MASTER];
         // a read with mastering off ends silently unless reporting is on
         transfer_error_ack <= cpu_req.valid && !cpu_req.write &&
            !cmd_r[pci_cs_pkg::CMD_MASTER] &&
            transfer_error_report_enable;
      end
   end
endmodule

/* File: tb/pci_agent_model.sv */
// Purpose: pci-side agent model raising bus event strobes
// Assumes: bench asks for one event pattern per request cycle
// Notes: strobes last one cycle and fall idle low in between
`timescale 1ns/1ns
module pci_agent_model (
   input wire logic pclk,
   input wire pci_cs_pkg::pci_event_t ev_req,
   output pci_cs_pkg::pci_event_t pci_event
);
   // registered so a strobe never lasts longer than the request
   always_ff @(posedge pclk) begin
      pci_event <= ev_req;
   end
endmodule

/* File: tb/pci_command_status_regs_chk.sv */
// Purpose: port-level checks of the command/status register bank
// Assumes: single pclk domain, async active-low reset
// Notes: bound onto every instance of the block
`timescale 1ns/1ns
module pci_cs_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire pci_cs_pkg::tgt_cmd_t tgt_cmd,
   input wire pci_cs_pkg::cpu_req_t cpu_req,
   input wire logic master_enable_r,
   input wire logic mem_claim_r,
   input wire logic fast_devsel_r,
   input wire logic use_plain_write_r,
   input wire logic cpu_write_drop_r,
   input wire logic transfer_error_ack,
   input wire logic cpu_req_forward_r
);
   // qualified requests, so $past sees one signal
   wire logic mem_hit = tgt_cmd.valid && tgt_cmd.is_mem && !tgt_cmd.is_io
      && !tgt_cmd.is_special;
   wire logic rd_req = cpu_req.valid && !cpu_req.write;
   wire logic rd_cmd = pready && !pwrite && paddr == pci_cs_pkg::CMD_ADDR;
   wire logic rd_sts = pready && !pwrite && paddr == pci_cs_pkg::STS_ADDR;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // some tie an output to its cause at the inputs; others tie it to another output or a constant
   a_answer_once: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("answer missing or too long");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   a_cmd_hardwired:
      assert property (rd_cmd |-> prdata[5:3] == 3'h0 && !prdata[0])
      else $error("command hardwired bit set");
   a_sts_hardwired:
      assert property (rd_sts |-> prdata[7:0] == 8'h80 && !prdata[10:9])
      else $error("status hardwired bits wrong");
   a_fwd_master:
      assert property (cpu_req_forward_r |-> master_enable_r)
      else $error("forward while mastering off");
   a_drop_write:
      assert property (cpu_write_drop_r |-> !master_enable_r
         && $past(cpu_req.write)) else $error("bad write drop");
   a_error_ack:
      assert property (transfer_error_ack |-> !master_enable_r
         && $past(rd_req)) else $error("bad error ack");
   a_claim_mem:
      assert property (mem_claim_r |-> $past(mem_hit))
      else $error("claim without memory command");
   a_fixed_outs:
      assert property (fast_devsel_r && use_plain_write_r)
      else $error("fixed output dropped");
   c_error_ack: cover property (transfer_error_ack);
   c_claim: cover property (mem_claim_r);
   c_refused: cover property (pslverr);
endmodule
bind pci_command_status_regs pci_cs_chk chk_u (.*);

/* File: tb/tb_pci_command_status_regs.sv */
// Purpose: directed bench for the command/status register bank
// Assumes: one access cycle per apb transfer, waits still bounded
// Notes: cpu and target requests are one-cycle stimulus pulses
`timescale 1ns/1ns
module tb_pci_command_status_regs;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rv;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, se, master_enable_r, mem_claim_r;
   logic cpu_write_drop_r, transfer_error_ack, cpu_req_forward_r;
   logic serr_drive_r, perr_action_r, fast_devsel_r, use_plain_write_r;
   pci_cs_pkg::pci_event_t ev_req = '0, pci_event;
   pci_cs_pkg::tgt_cmd_t tgt_cmd = '0;
   pci_cs_pkg::cpu_req_t cpu_req = '0;
   int failures = 0, n_compared = 0;
   localparam logic [11:0] C = pci_cs_pkg::CMD_ADDR;
   localparam logic [11:0] S = pci_cs_pkg::STS_ADDR;
   localparam logic [11:0] T = pci_cs_pkg::CTL_ADDR;
   pci_command_status_regs dut_u (.*);
   pci_agent_model agent_u (.pclk(pclk), .ev_req(ev_req),
      .pci_event(pci_event));
   always #4 pclk = ~pclk;
   task automatic complete_run;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] v, e);
      n_compared++;
      if (v !== e) begin
         failures++;
         $display("MISMATCH %s exp %h got %h", s, e, v);
      end
   endtask
   // setup, access until pready, then release at that edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // ready, data and error are taken at the rising edge itself
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rv = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         failures++;
         complete_run();
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e,
      input string s);
      apb(1'b0, a, 32'h0);
      chk(s, rv, {16'h0, e});
   endtask
   task automatic ev(input logic [6:0] e);
      @(posedge pclk);
      ev_req <= e;
      @(posedge pclk);
      ev_req <= '0;
   endtask
   task automatic side(input logic [3:0] t, input logic [1:0] c);
      @(posedge pclk);
      tgt_cmd <= t;
      cpu_req <= c;
      @(posedge pclk);
      tgt_cmd <= '0;
      cpu_req <= '0;
      @(negedge pclk);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(C, pci_cs_pkg::CMD_RESET, "cmd_reset");
      rd(S, pci_cs_pkg::STS_FIXED, "sts_reset");
      rd(T, 16'h0, "ctl_reset");
      apb(1'b1, C, 32'hFFFF_FFFF);
      rd(C, pci_cs_pkg::CMD_WMASK, "cmd_mask");
      chk("serr_on", {31'h0, serr_drive_r}, 32'h1);
      chk("perr_on", {31'h0, perr_action_r}, 32'h1);
      chk("fixed_devsel", {31'h0, fast_devsel_r}, 32'h1);
      chk("plain_write", {31'h0, use_plain_write_r}, 32'h1);
      apb(1'b1, S, 32'hFFFF_FFFF);
      rd(S, 16'h0080, "sts_noset");
      ev(7'h7E);
      rd(S, 16'hF980, "sts_all");
      apb(1'b1, S, 32'h0000_4000);
      rd(S, 16'hB980, "sts_clr14");
      apb(1'b1, S, 32'h0000_FFFF);
      rd(S, 16'h0080, "ma_cleared");
      ev(7'h0D);
      rd(S, 16'h0080, "sts_special");
      apb(1'b1, C, 32'h0000_0004);
      ev(7'h70);
      rd(S, 16'h8080, "sts_noresp");
      side(4'hC, 2'h2);
      chk("claim_off", {31'h0, mem_claim_r}, 32'h0);
      chk("forward", {31'h0, cpu_req_forward_r}, 32'h1);
      apb(1'b1, C, 32'h0000_0000);
      apb(1'b1, T, 32'h0000_0001);
      chk("master_off", {31'h0, master_enable_r}, 32'h0);
      chk("serr_off", {31'h0, serr_drive_r}, 32'h0);
      side(4'h0, 2'h2);
      chk("tea_on", {31'h0, transfer_error_ack}, 32'h1);
      side(4'h0, 2'h3);
      chk("drop", {31'h0, cpu_write_drop_r}, 32'h1);
      apb(1'b1, T, 32'h0000_0000);
      side(4'h0, 2'h2);
      chk("tea_off", {31'h0, transfer_error_ack}, 32'h0);
      apb(1'b1, C, 32'h0000_0002);
      side(4'hC, 2'h0);
      chk("claim_on", {31'h0, mem_claim_r}, 32'h1);
      side(4'hE, 2'h0);
      chk("claim_io", {31'h0, mem_claim_r}, 32'h0);
      side(4'hD, 2'h0);
      chk("claim_sc", {31'h0, mem_claim_r}, 32'h0);
      apb(1'b0, 12'hFFC, 32'h0);
      chk("unmapped", {31'h0, se}, 32'h1);
      complete_run();
   end
endmodule
